// ==== design/pfrw_defs.svh ====
// Purpose: Constants for the program flash row writer
// Assumes: 32-bit AHB-Lite register window, word aligned
// Notes:   Offsets are byte addresses
`ifndef PFRW_DEFS_SVH
`define PFRW_DEFS_SVH

`define PFRW_OFS_ADDR_LOW   8'h00
`define PFRW_OFS_ADDR_HIGH  8'h04
`define PFRW_OFS_DATA_LOW   8'h08
`define PFRW_OFS_DATA_HIGH  8'h0c
`define PFRW_OFS_CTRL       8'h10
`define PFRW_OFS_KEY        8'h14
`define PFRW_OFS_STATUS     8'h18

`define PFRW_KEY_FIRST      8'h55
`define PFRW_KEY_SECOND     8'haa

`define PFRW_BIT_RD         0
`define PFRW_BIT_WR         1
`define PFRW_BIT_ALLOW      2
`define PFRW_BIT_START_ERR  3
`define PFRW_BIT_FREE       4
`define PFRW_BIT_LATCH_ONLY 5
`define PFRW_BIT_CFG_SPACE  6
`define PFRW_STAT_BUSY      0
`define PFRW_STAT_ARMED     1

`define PFRW_BLANK_WORD     14'h3fff
`define PFRW_PROG_TIME_NS   2000
`define PFRW_ERASE_TIME_NS  2000
`define PFRW_CLK_NS         20

`endif

// ==== design/pfrw_pkg.sv ====
// Purpose: Types for the program flash row writer
// Assumes: Constants come from pfrw_defs.svh
// Notes:   Array request travels as one packed struct
package pfrw_pkg;

  typedef enum logic [1:0] {
    PFRW_IDLE   = 2'b00,
    PFRW_KEY1   = 2'b01,
    PFRW_ARMED  = 2'b11
  } pfrw_unlock_t;

  typedef enum logic [1:0] {
    PFRW_RUN_IDLE  = 2'b00,
    PFRW_RUN_PROG  = 2'b01,
    PFRW_RUN_ERASE = 2'b11,
    PFRW_RUN_DONE  = 2'b10
  } pfrw_run_t;

  typedef struct packed {
    logic        prog;
    logic        erase;
    logic [10:0] row;
    logic [3:0]  slot;
  } pfrw_array_req_t;

endpackage

// ==== design/pfrw_latch_bank.sv ====
// Purpose: Bank of write latches feeding the array row program
// Assumes: One load or one slot read per cycle
// Notes:   Read data comes out of a register
`include "pfrw_defs.svh"
module pfrw_latch_bank
  import pfrw_pkg::*;
#(
  parameter int WORDS = 16,
  parameter int WIDTH = 14
)(
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     load,
  input  wire logic [$clog2(WORDS)-1:0] load_slot,
  input  wire logic [WIDTH-1:0]         load_word,
  input  wire logic                     blank_all,
  input  wire logic [$clog2(WORDS)-1:0] rd_slot,
  output logic      [WIDTH-1:0]         rd_word
);
  logic [WIDTH-1:0] mem_q [WORDS];
  logic [WIDTH-1:0] mem_d [WORDS];
  localparam int AW = $clog2(WORDS);

  logic [WIDTH-1:0] rd_d;

  // Slot select is a plain binary index, so the depth is a power of two
  if (WORDS < 2 || WORDS != (1 << AW) || WIDTH != 14)
  begin : g_bad_size
    $error("pfrw_latch_bank: unsupported size");
  end

  for (genvar i = 0; i < WORDS; i++)
  begin : g_slot
    always_comb
    begin
      mem_d[i] = mem_q[i];
      if (blank_all)
        mem_d[i] = `PFRW_BLANK_WORD;
      else if (load && load_slot == AW'(i))
        mem_d[i] = load_word;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        mem_q[i] <= `PFRW_BLANK_WORD;
      else
        mem_q[i] <= mem_d[i];
    end
  end

  always_comb
  begin
    rd_d = mem_q[rd_slot];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_word <= `PFRW_BLANK_WORD;
    else
      rd_word <= rd_d;
  end
endmodule

// ==== design/pfrw_unlock.sv ====
// Purpose: Two-key unlock guard for latch loads and row programs
// Assumes: One bus write per key, strobes from the bus slave
// Notes:   Any other bus write between the steps disarms
`include "pfrw_defs.svh"
module pfrw_unlock
  import pfrw_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_val,
  input  wire logic       other_wr,
  input  wire logic       start_wr,
  output logic            start_ok,
  output logic            armed
);
  pfrw_unlock_t st_q;
  pfrw_unlock_t st_d;

  always_comb
  begin
    st_d     = st_q;
    start_ok = 1'b0;
    unique case (st_q)
      PFRW_IDLE:
      begin
        if (key_wr && key_val == `PFRW_KEY_FIRST)
          st_d = PFRW_KEY1;
      end
      PFRW_KEY1:
      begin
        if (key_wr && key_val == `PFRW_KEY_SECOND)
          st_d = PFRW_ARMED;
        else if (key_wr || other_wr || start_wr)
          st_d = PFRW_IDLE;
      end
      PFRW_ARMED:
      begin
        // Only the very next write may start; anything else disarms
        if (start_wr)
          start_ok = 1'b1;
        if (key_wr || other_wr || start_wr)
          st_d = PFRW_IDLE;
      end
      default:
        st_d = PFRW_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_q <= PFRW_IDLE;
    else
      st_q <= st_d;
  end

  assign armed = (st_q == PFRW_ARMED);
endmodule

// ==== design/pfrw_top.sv ====
// Purpose: Self-write controller for on-chip program flash
// Assumes: AHB-Lite slave, single word transfers, 50 MHz hclk
// Notes:   Array port streams the latch row out one word per cycle
// Overview of operation
// - The array is erased only a whole row at a time.
// - Starting a program never erases the target row by itself.
// - Sixteen latches; one program writes one up to sixteen words.
// - Upper eleven address bits pick the row, low four the latch.
// - A program touches only the addressed row.
// - Every finished program or erase blanks all latches.
// - Latch load or program needs the unlock sequence just before.
// - A broken unlock sequence neither loads nor programs.
// - With latch-only set, an unlock only loads the addressed latch.
// - With latch-only clear, an unlock loads then programs the row.
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`include "pfrw_defs.svh"
module pfrw_top
  import pfrw_pkg::*;
#(
  parameter int PROG_CYCLES  = (`PFRW_PROG_TIME_NS + `PFRW_CLK_NS - 1)
                               / `PFRW_CLK_NS,
  parameter int ERASE_CYCLES = (`PFRW_ERASE_TIME_NS + `PFRW_CLK_NS - 1)
                               / `PFRW_CLK_NS
)(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  output pfrw_array_req_t            arr_req,
  output logic      [13:0]           arr_word,
  output logic                       cpu_stall
);
  localparam int CW = 16;

  if (PROG_CYCLES < 1 || ERASE_CYCLES < 1 || PROG_CYCLES > 65535
      || ERASE_CYCLES > 65535)
  begin : g_bad_cycles
    $error("pfrw_top: cycle counts out of range");
  end

  // Bus address phase capture
  logic       dp_wr_q, dp_wr_d;
  logic       dp_rd_q, dp_rd_d;
  logic [7:0] dp_addr_q, dp_addr_d;
  logic       ap_valid;

  assign ap_valid = hsel && hready && htrans[1];

  always_comb
  begin
    dp_wr_d   = ap_valid && hwrite;
    dp_rd_d   = ap_valid && !hwrite;
    dp_addr_d = ap_valid ? haddr : dp_addr_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      dp_addr_q <= 8'h00;
    end
    else
    begin
      dp_wr_q   <= dp_wr_d;
      dp_rd_q   <= dp_rd_d;
      dp_addr_q <= dp_addr_d;
    end
  end

  // Registers
  logic [7:0]  addr_lo_q, addr_lo_d;
  logic [6:0]  addr_hi_q, addr_hi_d;
  logic [7:0]  data_lo_q, data_lo_d;
  logic [5:0]  data_hi_q, data_hi_d;
  logic        program_write_allow_q, program_write_allow_d;
  logic        latch_only_select_q, latch_only_select_d;
  logic        config_space_select_q, config_space_select_d;
  logic        free_q, free_d;
  logic        wr_q, wr_d;
  logic        wrerr_q, wrerr_d;

  logic        w_alo, w_ahi, w_dlo, w_dhi, w_ctl, w_key, w_other;
  logic        start_req, start_ok, armed;

  assign w_alo = dp_wr_q && dp_addr_q == `PFRW_OFS_ADDR_LOW;
  assign w_ahi = dp_wr_q && dp_addr_q == `PFRW_OFS_ADDR_HIGH;
  assign w_dlo = dp_wr_q && dp_addr_q == `PFRW_OFS_DATA_LOW;
  assign w_dhi = dp_wr_q && dp_addr_q == `PFRW_OFS_DATA_HIGH;
  assign w_ctl = dp_wr_q && dp_addr_q == `PFRW_OFS_CTRL;
  assign w_key = dp_wr_q && dp_addr_q == `PFRW_OFS_KEY;
  assign start_req = w_ctl && hwdata[`PFRW_BIT_WR];
  assign w_other = dp_wr_q && !w_key && !start_req;

  pfrw_unlock u_unlock (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .key_wr   (w_key),
    .key_val  (hwdata[7:0]),
    .other_wr (w_other),
    .start_wr (start_req),
    .start_ok (start_ok),
    .armed    (armed)
  );

  // Sequencer
  pfrw_run_t   run_q, run_d;
  logic [15:0] cnt_q, cnt_d;
  logic [3:0]  slot_q, slot_d;
  logic        go, go_prog, go_erase, go_load;
  logic        lat_load, lat_blank;

  // Configuration space and a cleared write allow refuse the start
  assign go = start_ok && program_write_allow_q && !config_space_select_q
              && run_q == PFRW_RUN_IDLE;
  assign go_erase = go && hwdata[`PFRW_BIT_FREE];
  assign go_load  = go && !hwdata[`PFRW_BIT_FREE];
  assign go_prog  = go_load && !hwdata[`PFRW_BIT_LATCH_ONLY];
  assign lat_load = go_load;

  always_comb
  begin
    run_d     = run_q;
    cnt_d     = cnt_q;
    slot_d    = slot_q;
    lat_blank = 1'b0;
    unique case (run_q)
      PFRW_RUN_IDLE:
      begin
        slot_d = 4'h0;
        if (go_prog)
        begin
          run_d = PFRW_RUN_PROG;
          cnt_d = 16'(PROG_CYCLES);
        end
        else if (go_erase)
        begin
          run_d = PFRW_RUN_ERASE;
          cnt_d = 16'(ERASE_CYCLES);
        end
      end
      PFRW_RUN_PROG:
      begin
        // Stream all sixteen words while the program time counts down; leave once both are done
        if (slot_q != 4'hf)
          slot_d = slot_q + 4'h1;
        if (cnt_q > 16'h0001)
          cnt_d = cnt_q - 16'h0001;
        else if (slot_q == 4'hf)
          run_d = PFRW_RUN_DONE;
      end
      PFRW_RUN_ERASE:
      begin
        if (cnt_q > 16'h0001)
          cnt_d = cnt_q - 16'h0001;
        else
          run_d = PFRW_RUN_DONE;
      end
      PFRW_RUN_DONE:
      begin
        lat_blank = 1'b1;
        run_d     = PFRW_RUN_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_q  <= PFRW_RUN_IDLE;
      cnt_q  <= 16'h0000;
      slot_q <= 4'h0;
    end
    else
    begin
      run_q  <= run_d;
      cnt_q  <= cnt_d;
      slot_q <= slot_d;
    end
  end

  pfrw_latch_bank #(
    .WORDS (CW),
    .WIDTH (14)
  ) u_bank (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .load      (lat_load),
    .load_slot (addr_lo_q[3:0]),
    .load_word ({data_hi_q, data_lo_q}),
    .blank_all (lat_blank),
    .rd_slot   (slot_q),
    .rd_word   (arr_word)
  );

  // Array request; row is frozen for the whole operation
  logic [10:0] row_q, row_d;
  logic        prog_q, prog_d, erase_q, erase_d;

  always_comb
  begin
    row_d   = go ? {addr_hi_q, addr_lo_q[7:4]} : row_q;
    prog_d  = run_d == PFRW_RUN_PROG;
    erase_d = run_d == PFRW_RUN_ERASE;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      row_q   <= 11'h000;
      prog_q  <= 1'b0;
      erase_q <= 1'b0;
    end
    else
    begin
      row_q   <= row_d;
      prog_q  <= prog_d;
      erase_q <= erase_d;
    end
  end

  assign arr_req.prog  = prog_q;
  assign arr_req.erase = erase_q;
  assign arr_req.row   = row_q;
  assign arr_req.slot  = slot_q;
  // The core waits the row out rather than racing a busy array
  assign cpu_stall = run_q != PFRW_RUN_IDLE;

  // Register write side
  always_comb
  begin
    addr_lo_d = w_alo ? hwdata[7:0] : addr_lo_q;
    addr_hi_d = w_ahi ? hwdata[6:0] : addr_hi_q;
    data_lo_d = w_dlo ? hwdata[7:0] : data_lo_q;
    data_hi_d = w_dhi ? hwdata[5:0] : data_hi_q;
    free_d    = w_ctl ? hwdata[`PFRW_BIT_FREE] : free_q;
    program_write_allow_d = program_write_allow_q;
    latch_only_select_d   = latch_only_select_q;
    config_space_select_d = config_space_select_q;
    if (w_ctl)
    begin
      program_write_allow_d = hwdata[`PFRW_BIT_ALLOW];
      latch_only_select_d   = hwdata[`PFRW_BIT_LATCH_ONLY];
      config_space_select_d = hwdata[`PFRW_BIT_CFG_SPACE];
    end
    wr_d      = wr_q;
    if (go_prog || go_erase)
      wr_d = 1'b1;
    else if (run_q == PFRW_RUN_DONE)
      wr_d = 1'b0;
    // Start without a live unlock is flagged, never acted on
    wrerr_d = wrerr_q;
    if (start_req && !go)
      wrerr_d = 1'b1;
    else if (w_ctl)
      wrerr_d = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_lo_q <= 8'h00;
      addr_hi_q <= 7'h00;
      data_lo_q <= 8'h00;
      data_hi_q <= 6'h00;
      program_write_allow_q <= 1'b0;
      latch_only_select_q   <= 1'b0;
      config_space_select_q <= 1'b0;
      free_q    <= 1'b0;
      wr_q      <= 1'b0;
      wrerr_q   <= 1'b0;
    end
    else
    begin
      addr_lo_q <= addr_lo_d;
      addr_hi_q <= addr_hi_d;
      data_lo_q <= data_lo_d;
      data_hi_q <= data_hi_d;
      program_write_allow_q <= program_write_allow_d;
      latch_only_select_q   <= latch_only_select_d;
      config_space_select_q <= config_space_select_d;
      free_q    <= free_d;
      wr_q      <= wr_d;
      wrerr_q   <= wrerr_d;
    end
  end

  // Read side; answered in the data phase with no wait states
  logic [31:0] rdata;

  always_comb
  begin
    rdata = 32'h0000_0000;
    if (dp_rd_q)
    begin
      unique case (dp_addr_q)
        `PFRW_OFS_ADDR_LOW:  rdata[7:0] = addr_lo_q;
        `PFRW_OFS_ADDR_HIGH: rdata[6:0] = addr_hi_q;
        `PFRW_OFS_DATA_LOW:  rdata[7:0] = data_lo_q;
        `PFRW_OFS_DATA_HIGH: rdata[5:0] = data_hi_q;
        `PFRW_OFS_CTRL:
        begin
          rdata[`PFRW_BIT_WR]         = wr_q;
          rdata[`PFRW_BIT_ALLOW]      = program_write_allow_q;
          rdata[`PFRW_BIT_FREE]       = free_q;
          rdata[`PFRW_BIT_LATCH_ONLY] = latch_only_select_q;
          rdata[`PFRW_BIT_CFG_SPACE]  = config_space_select_q;
          rdata[`PFRW_BIT_START_ERR]  = wrerr_q;
        end
        `PFRW_OFS_STATUS:
        begin
          rdata[`PFRW_STAT_BUSY]  = cpu_stall;
          rdata[`PFRW_STAT_ARMED] = armed;
        end
        default:             rdata = 32'h0000_0000;
      endcase
    end
  end

  assign hrdata    = rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule

// ==== tb/pfrw_props.sv ====
// Purpose: Port-level checks for the flash row writer
// Assumes: Bound to pfrw_top, one clock domain
// Notes:   Keeps the last three bus writes to judge each row program
`include "pfrw_defs.svh"
module pfrw_props
  import pfrw_pkg::*;
#(
  parameter int PROG_CYCLES  = 100,
  parameter int ERASE_CYCLES = 100
)(
  input wire logic            hclk,
  input wire logic            hresetn,
  input wire logic            hsel,
  input wire logic [7:0]      haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic [31:0]     hwdata,
  input wire logic            hready,
  input wire pfrw_array_req_t arr_req,
  input wire logic            cpu_stall
);
  logic        dp_q;
  logic        dp_d;
  logic [7:0]  da_q;
  logic [7:0]  da_d;
  logic [15:0] h0_q;
  logic [15:0] h1_q;
  logic [15:0] h2_q;
  logic [15:0] h0_d;
  logic [15:0] h1_d;
  logic [15:0] h2_d;

  always_comb
  begin
    dp_d = hsel & hready & htrans[1] & hwrite;
    da_d = dp_d ? haddr : da_q;
    h0_d = dp_q ? {da_q, hwdata[7:0]} : h0_q;
    h1_d = dp_q ? h0_q : h1_q;
    h2_d = dp_q ? h1_q : h2_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_q <= 1'b0;
      da_q <= 8'h00;
      h0_q <= 16'h0000;
      h1_q <= 16'h0000;
      h2_q <= 16'h0000;
    end
    else
    begin
      dp_q <= dp_d;
      da_q <= da_d;
      h0_q <= h0_d;
      h1_q <= h1_d;
      h2_q <= h2_d;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_run;
    arr_req.prog [*8];
  endsequence
  // Keys in order, then a start with latch-only clear
  sequence s_keys;
    h2_q == {`PFRW_OFS_KEY, `PFRW_KEY_FIRST} &&
    h1_q == {`PFRW_OFS_KEY, `PFRW_KEY_SECOND} &&
    h0_q[15:8] == `PFRW_OFS_CTRL && h0_q[1] && !h0_q[5];
  endsequence

  a_prog_after_keys: assert property (
    $rose(arr_req.prog) |-> s_keys) else $error("program without unlock");
  a_no_auto_erase: assert property (
    arr_req.prog |-> !arr_req.erase) else $error("erase during program");
  a_erase_asked: assert property (
    $rose(arr_req.erase) |-> h0_q[15:8] == `PFRW_OFS_CTRL &&
    h0_q[`PFRW_BIT_FREE] && h1_q == {`PFRW_OFS_KEY, `PFRW_KEY_SECOND})
    else $error("erase without request");
  a_stall_prog: assert property (
    arr_req.prog |-> cpu_stall) else $error("core not held in program");
  a_row_stable: assert property (
    arr_req.prog && $past(arr_req.prog) |-> $stable(arr_req.row))
    else $error("row changed in program");
  a_slot_first: assert property (
    $rose(arr_req.prog) |-> arr_req.slot == 4'h0)
    else $error("row stream not at slot zero");
  a_slot_steps: assert property (
    arr_req.prog && $past(arr_req.prog) && $past(arr_req.slot) != 4'hf
    |-> arr_req.slot == $past(arr_req.slot) + 4'h1)
    else $error("slot did not step by one");
  a_prog_min_run: assert property (
    $rose(arr_req.prog) |-> s_run) else $error("program ended early");
  a_prog_ends: assert property (
    $rose(arr_req.prog) |-> ##[9:60] !arr_req.prog)
    else $error("program never ended");
endmodule

bind pfrw_top pfrw_props #(
  .PROG_CYCLES  (PROG_CYCLES),
  .ERASE_CYCLES (ERASE_CYCLES)
) chk_u (
  .hclk      (hclk),
  .hresetn   (hresetn),
  .hsel      (hsel),
  .haddr     (haddr),
  .htrans    (htrans),
  .hwrite    (hwrite),
  .hwdata    (hwdata),
  .hready    (hready),
  .arr_req   (arr_req),
  .cpu_stall (cpu_stall)
);

// ==== tb/program_flash_row_writer_test.sv ====
// Purpose: Self-checking bench for the flash row writer
// Assumes: Zero wait state slave, short program time of 4 cycles
// Notes:   Latch contents are judged from the streamed row program
`include "pfrw_defs.svh"
module program_flash_row_writer_test
  import pfrw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic            hclk = 1'b0;
  logic            hresetn = 1'b0;
  logic            hsel = 1'b0;
  logic            hwrite = 1'b0;
  logic [7:0]      haddr = 8'h00;
  logic [1:0]      htrans = 2'b00;
  logic [31:0]     hwdata = 32'h0;
  logic [31:0]     hrdata;
  logic [31:0]     rd;
  logic            hreadyout;
  logic            hresp;
  logic            cpu_stall;
  logic [13:0]     arr_word;
  pfrw_array_req_t arr_req;
  logic [13:0]     ex [16];
  logic [10:0]     row;
  int              n_fail = 0;
  int              samples_checked = 0;
  int              cyc = 0;

  pfrw_top #(.PROG_CYCLES(4), .ERASE_CYCLES(4)) dut_u (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (3'b010),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .arr_req   (arr_req),
    .arr_word  (arr_word),
    .cpu_stall (cpu_stall)
  );

  always #10 hclk = ~hclk;

  task automatic finish_test;
    $display("Summary: %0d checked, %0d failed", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // The whole run needs about 200 cycles
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      finish_test;
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Mode 0 full unlock, 1 no keys, 2 keys broken by another write
  task automatic load(input logic [3:0] s, input logic [13:0] w,
                      input logic [7:0] c, input int m);
    bus(1'b1, `PFRW_OFS_ADDR_LOW, {24'h0, row[3:0], s});
    bus(1'b1, `PFRW_OFS_DATA_LOW, {24'h0, w[7:0]});
    bus(1'b1, `PFRW_OFS_DATA_HIGH, {26'h0, w[13:8]});
    if (m != 1)
      bus(1'b1, `PFRW_OFS_KEY, {24'h0, `PFRW_KEY_FIRST});
    if (m == 2)
      bus(1'b1, `PFRW_OFS_DATA_LOW, {24'h0, w[7:0]});
    if (m != 1)
      bus(1'b1, `PFRW_OFS_KEY, {24'h0, `PFRW_KEY_SECOND});
    bus(1'b1, `PFRW_OFS_CTRL, {24'h0, c});
  endtask

  task automatic set_row(input logic [10:0] r);
    row = r;
    bus(1'b1, `PFRW_OFS_ADDR_HIGH, {25'h0, r[10:4]});
    for (int i = 0; i < 16; i++)
      ex[i] = `PFRW_BLANK_WORD;
  endtask

  // Word lags slot by one cycle on the array port
  task automatic watch_row;
    logic [3:0]  sl [17];
    logic [13:0] wd [17];
    int          k;
    k = 0;
    do
    begin
      @(negedge hclk);
      k++;
    end
    while (arr_req.prog !== 1'b1 && k < 50);
    cmp(cpu_stall, 1'b1, "stall");
    cmp(arr_req.row, row, "row");
    for (k = 0; k < 17; k++)
    begin
      sl[k] = arr_req.slot;
      wd[k] = arr_word;
      @(negedge hclk);
    end
    for (k = 0; k < 16; k++)
    begin
      cmp(sl[k], k[3:0], "slot");
      cmp(wd[k + 1], ex[k], "word");
    end
    k = 0;
    while (cpu_stall !== 1'b0 && k < 50)
    begin
      @(negedge hclk);
      k++;
    end
    @(posedge hclk);
    bus(1'b0, `PFRW_OFS_CTRL, 32'h0);
    cmp(rd[1], 1'b0, "start bit");
  endtask

  task automatic t_reset;
    cmp(arr_word, `PFRW_BLANK_WORD, "reset word");
    cmp(cpu_stall, 1'b0, "reset stall");
    cmp({hreadyout, hresp}, 2'b10, "bus answer");
    bus(1'b0, `PFRW_OFS_STATUS, 32'h0);
    cmp(rd, 32'h0, "reset status");
    $display("test reset done");
  endtask

  task automatic t_refuse;
    set_row(11'h5a3);
    bus(1'b1, `PFRW_OFS_CTRL, 32'h44);
    load(4'h5, 14'h1234, 8'h46, 0);
    bus(1'b0, `PFRW_OFS_CTRL, 32'h0);
    cmp(rd[6], 1'b1, "config bit");
    cmp(rd[3], 1'b1, "config refused");
    bus(1'b1, `PFRW_OFS_CTRL, 32'h24);
    load(4'h5, 14'h1234, 8'h06, 1);
    bus(1'b0, `PFRW_OFS_CTRL, 32'h0);
    cmp(rd[3], 1'b1, "start error");
    load(4'h6, 14'h0abc, 8'h06, 2);
    repeat (3) @(posedge hclk);
    cmp(cpu_stall, 1'b0, "broken unlock");
    $display("test refuse done");
  endtask

  task automatic t_program;
    load(4'h0, 14'h0111, 8'h26, 0);
    cmp(cpu_stall, 1'b0, "latch only");
    load(4'h1, 14'h2222, 8'h26, 0);
    load(4'h2, 14'h3ffe, 8'h26, 0);
    ex[0] = 14'h0111;
    ex[1] = 14'h2222;
    ex[2] = 14'h3ffe;
    ex[15] = 14'h0a5a;
    load(4'hf, 14'h0a5a, 8'h06, 0);
    watch_row;
    set_row(11'h001);
    ex[7] = 14'h1357;
    load(4'h7, 14'h1357, 8'h06, 0);
    watch_row;
    $display("test program done");
  endtask

  task automatic t_erase;
    int k;
    set_row(11'h2c4);
    load(4'h0, 14'h0000, 8'h16, 0);
    k = 0;
    do
    begin
      @(negedge hclk);
      k++;
    end
    while (arr_req.erase !== 1'b1 && k < 50);
    cmp(arr_req.row, row, "erase row");
    cmp(arr_req.prog, 1'b0, "erase only");
    cmp(cpu_stall, 1'b1, "erase stall");
    repeat (10) @(posedge hclk);
    cmp(cpu_stall, 1'b0, "erase end");
    $display("test erase done");
  endtask

  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_refuse;
    t_program;
    t_erase;
    finish_test;
  end
endmodule
